/* File: src/ptm_timer.sv */
// periodic timer: compare, pwm, single pulse, capture and timer modes
// Notes on behaviour
// R1: mode 11 behaves like compare match mode, raising both match flags.
// R2: timer/counter mode never drives the output pin.
// R3: software selects pwm with mode 10 and output function 10.
// R4: pwm period set by period match clearing counter; duty by compare a.
// R5: pwm period equals period value; zero gives 1024 counts.
// R6: compare a at or above period gives full duty.
// R7: pwm raises match a and match p flags on their matches.
// R8: init level selects polarity; output function passes pwm or forces level.
// R9: invert bit inverts the pwm waveform on the pin.
// R10: pwm counting and flags continue while output is forced.
// R11: single pulse uses mode 10, function 11, unchanged while used.
// R12: run rising starts counter and pulse; ext clock edge sets run.
// R13: pulse ends on run cleared or match a, which clears run.
// R14: single pulse counter resets only on run rising; period unused.
// R15: mode 01 captures on selected pin; counting starts with run.
// R16: function bits choose rising, falling or both edges; 11 no capture.
// R17: capture latches counter into compare a or capture b, flags event; only captures into compare a raise match a here.
// R18: capture counter free runs; period match clears it and flags.
// R19: capture clear select adds rising, falling or both edge clears.
// R20: with clear select 00 captures go to compare a only.
// R21: capture pulses below two timer clocks may be ignored.
// R22: clear source, init level and invert unused in capture.
// R23: edge flag reads 1 for rising, 0 for falling latch.
// R24: counter is 10 bits, readable as low and high bytes.
// R25: pwm active while counter below compare a.
`include "ptm_defines.svh"
module ptm_timer
    import ptm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // pins
    input  wire logic        ext_clock_pin,
    input  wire logic        capture_pin,
    output ptm_pin_s         timer_out,
    // event pulses
    output logic             match_a_evt,
    output logic             match_p_evt
);
    ptm_ctrl_s        ctrl;
    logic [1:0]       capture_clear_sel;
    logic [9:0]       cnt;
    logic [9:0]       compare_a_value;
    logic [9:0]       capture_b_value;
    logic [9:0]       period_value;
    logic             match_a_flag;
    logic             match_p_flag;
    logic             latch_edge_flag;
    logic             out_state;
    logic             run_d;
    logic [3:0]       div_cnt;
    logic             ack;
    logic [1:0]       ck_sync;
    logic [1:0]       pi_sync;
    logic             ck_q;
    logic             pi_q;

    // two-stage synchronisers; stage two and its one-cycle delayed copy are read
    always_ff @(posedge clk) begin
        if (rst) begin
            ck_sync <= 2'b00;
            pi_sync <= 2'b00;
            ck_q    <= 1'b0;
            pi_q    <= 1'b0;
        end else begin
            ck_sync <= {ck_sync[0], ext_clock_pin};
            pi_sync <= {pi_sync[0], capture_pin};
            ck_q    <= ck_sync[1];
            pi_q    <= pi_sync[1];
        end
    end

    // timer clock enable from divider
    wire tick     = (div_cnt == ctrl.clk_div);
    always_ff @(posedge clk) begin
        if (rst || tick)
            div_cnt <= 4'h0;
        else
            div_cnt <= div_cnt + 4'h1;
    end

    // bus decode; one wait cycle per access
    wire acc      = (avs_read | avs_write) & ~ack;
    wire wr_go    = avs_write & ack;
    wire wr_ctrl  = wr_go && avs_address == `PTM_OFF_CTRL  && avs_byteenable[0];
    wire wr_ctrl1 = wr_go && avs_address == `PTM_OFF_CTRL  && avs_byteenable[1];
    wire wr_ctrl2 = wr_go && avs_address == `PTM_OFF_CTRL2 && avs_byteenable[0];
    wire wr_a     = wr_go && avs_address == `PTM_OFF_COMPARE_A_VALUE;
    wire wr_b     = wr_go && avs_address == `PTM_OFF_CAPTURE_B_VALUE;
    wire wr_p     = wr_go && avs_address == `PTM_OFF_PERIOD_VALUE;
    wire wr_flag  = wr_go && avs_address == `PTM_OFF_FLAGS && avs_byteenable[0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    always_ff @(posedge clk) begin
        if (rst)
            ack <= 1'b0;
        else
            ack <= acc;
    end

    // mode decode
    wire m_cap    = ctrl.mode == PTM_MODE_CAP;
    wire m_pwm    = ctrl.mode == PTM_MODE_PWM && ctrl.out_func_sel != 2'b11;
    wire m_sp     = ctrl.mode == PTM_MODE_PWM && ctrl.out_func_sel == 2'b11;
    wire m_cmp    = ctrl.mode == PTM_MODE_CMP || ctrl.mode == PTM_MODE_TIMER; // R1

    // capture source and edges
    wire cap_now  = ctrl.capture_src_sel ? ck_sync[1] : pi_sync[1]; // R15
    wire cap_old  = ctrl.capture_src_sel ? ck_q : pi_q;
    wire rise     = cap_now & ~cap_old;
    wire fall     = ~cap_now & cap_old;
    wire ck_rise  = ck_sync[1] & ~ck_q;

    // comparators
    wire [9:0] nxt    = cnt + 10'h001;
    wire eq_p     = (period_value == 10'h000) ? (cnt == `PTM_CNT_MAX)
                                              : (nxt == period_value); // R5 R18
    wire eq_a     = (compare_a_value == 10'h000) ? 1'b0 : (nxt == compare_a_value);
    wire run_rise = ctrl.run & ~run_d;
    // no match on a stale count in the cycle that run rises
    wire running  = ctrl.run & tick & ~run_rise;
    wire a_hit    = running & eq_a & ~m_cap;
    wire p_hit    = running & eq_p & ~m_sp                      // R14
                    & ~(m_cmp & ctrl.clear_src_sel);
    wire cap_edge = ctrl.run & m_cap &                          // R16 R21
                    ((ctrl.out_func_sel == 2'b00 & rise) |
                     (ctrl.out_func_sel == 2'b01 & fall) |
                     (ctrl.out_func_sel == 2'b10 & (rise | fall)));
    wire edge_clr = ctrl.run & m_cap &                          // R19
                    ((capture_clear_sel == 2'b01 & rise) |
                     (capture_clear_sel == 2'b10 & fall) |
                     (capture_clear_sel == 2'b11 & (rise | fall)));
    wire to_b     = cap_edge & (capture_clear_sel != 2'b00) & fall; // R17 R20
    wire clr_cnt  = run_rise | p_hit | edge_clr                 // R4 R18
                    | (m_cmp & ctrl.clear_src_sel & a_hit);
    wire sp_end   = m_sp & a_hit;                               // R13
    wire sp_start = m_sp & ck_rise;                             // R12
    assign match_a_evt = a_hit | (cap_edge & ~to_b);            // R7 R17
    assign match_p_evt = p_hit;                                 // R7

    // counter
    always_ff @(posedge clk) begin
        if (rst)
            cnt <= 10'h000;
        else if (clr_cnt)
            cnt <= 10'h000;
        else if (running)
            cnt <= nxt;
    end

    // control registers, run auto set and clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl              <= ptm_ctrl_s'(`PTM_CTRL_RST);
            capture_clear_sel <= 2'b00;
            run_d             <= 1'b0;
        end else begin
            run_d <= ctrl.run;
            if (wr_ctrl)
                {ctrl.mode, ctrl.out_func_sel, ctrl.out_init_level, ctrl.out_invert,
                 ctrl.capture_src_sel, ctrl.clear_src_sel} <= avs_writedata[7:0];
            if (wr_ctrl1)
                {ctrl.clk_div, ctrl.run} <= {avs_writedata[15:12], avs_writedata[8]};
            if (sp_start)
                ctrl.run <= 1'b1;                               // R12
            else if (sp_end)
                ctrl.run <= 1'b0;                               // R13
            if (wr_ctrl2)
                capture_clear_sel <= avs_writedata[`PTM_B_TCLR +: 2];
        end
    end

    // compare values; capture overrides a software write
    always_ff @(posedge clk) begin
        if (rst) begin
            compare_a_value <= 10'h000;
            capture_b_value <= 10'h000;
            period_value    <= 10'h000;
            latch_edge_flag <= 1'b0;
        end else begin
            if (cap_edge & ~to_b)
                compare_a_value <= cnt;                         // R17
            else if (wr_a)
                compare_a_value <= avs_writedata[9:0];
            if (to_b)
                capture_b_value <= cnt;
            else if (wr_b)
                capture_b_value <= avs_writedata[9:0];
            if (wr_p)
                period_value <= avs_writedata[9:0];
            if (cap_edge)
                latch_edge_flag <= rise;                        // R23
        end
    end

    // sticky flags: set wins over clear by write-one
    always_ff @(posedge clk) begin
        if (rst) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            match_a_flag <= match_a_evt | (match_a_flag & ~(wr_flag & avs_writedata[0]));
            match_p_flag <= match_p_evt | (match_p_flag & ~(wr_flag & avs_writedata[1]));
        end
    end

    // output waveform
    wire [10:0] per   = (period_value == 10'h000) ? 11'h400 : {1'b0, period_value};
    wire pwm_act  = ({1'b0, compare_a_value} >= per) | (cnt < compare_a_value); // R6 R25
    wire pwm_lvl  = (pwm_act ~^ ctrl.out_init_level) ^ ctrl.out_invert;       // R8 R9
    always_ff @(posedge clk) begin
        if (rst)
            out_state <= 1'b0;
        else if (m_cmp & run_rise)
            out_state <= ctrl.out_init_level;
        else if (m_cmp & a_hit)
            case (ctrl.out_func_sel)
                2'b01:   out_state <= 1'b1;
                2'b10:   out_state <= 1'b0;
                2'b11:   out_state <= ~out_state;
                default: out_state <= out_state;
            endcase
    end

    always_comb begin
        timer_out.out_oe  = 1'b0;                               // R2 R22
        timer_out.out_val = 1'b0;
        if (ctrl.mode == PTM_MODE_CMP) begin
            timer_out.out_oe  = 1'b1;
            timer_out.out_val = out_state ^ ctrl.out_invert;
        end else if (m_pwm) begin
            timer_out.out_oe  = 1'b1;                           // R10
            case (ctrl.out_func_sel)
                2'b00:   timer_out.out_val = 1'b0;
                2'b01:   timer_out.out_val = 1'b1;
                default: timer_out.out_val = pwm_lvl;
            endcase
        end else if (m_sp) begin
            timer_out.out_oe  = 1'b1;
            timer_out.out_val = (ctrl.run ~^ ctrl.out_init_level) ^ ctrl.out_invert;
        end
    end

    // read mux, registered data
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            `PTM_OFF_CTRL:  rd_mux = {16'h0000, ctrl.clk_div, 3'b000, ctrl.run,
                                      ctrl.mode, ctrl.out_func_sel, ctrl.out_init_level,
                                      ctrl.out_invert, ctrl.capture_src_sel,
                                      ctrl.clear_src_sel};
            `PTM_OFF_CTRL2: rd_mux = {29'h0, capture_clear_sel, latch_edge_flag};
            `PTM_OFF_CNT:   rd_mux = {22'h0, cnt};              // R24
            `PTM_OFF_COMPARE_A_VALUE:  rd_mux = {22'h0, compare_a_value};
            `PTM_OFF_CAPTURE_B_VALUE:  rd_mux = {22'h0, capture_b_value};
            `PTM_OFF_PERIOD_VALUE:  rd_mux = {22'h0, period_value};
            `PTM_OFF_FLAGS: rd_mux = {29'h0, latch_edge_flag, match_p_flag, match_a_flag};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (acc)
            avs_readdata <= rd_mux;
    end

    // single pulse
    sequence sp_done_s;
        ctrl.run == 1'b0;
    endsequence
    sequence sp_lead_s;
        timer_out.out_oe && timer_out.out_val == (ctrl.out_init_level ^ ctrl.out_invert);
    endsequence

    sp_clear_a: assert property (@(posedge clk) disable iff (rst) // R13
        sp_end && !sp_start |=> sp_done_s)
        else $error("match a did not stop pulse");

    sp_irq_a: assert property (@(posedge clk) disable iff (rst) // R13
        sp_end |-> match_a_evt)
        else $error("pulse end raised no event");

    sp_arm_a: assert property (@(posedge clk) disable iff (rst) // R12
        sp_start |=> ctrl.run)
        else $error("pin edge did not set run");

    sp_lead_a: assert property (@(posedge clk) disable iff (rst) // R12 R14
        m_sp && run_rise |-> sp_lead_s ##1 cnt == 10'h000)
        else $error("pulse did not start");

    run_clear_a: assert property (@(posedge clk) disable iff (rst) // R14
        run_rise |=> cnt == 10'h000)
        else $error("counter not reset");

    // pin drive and waveform
    tc_nodrive_a: assert property (@(posedge clk) disable iff (rst) // R2
        ctrl.mode == PTM_MODE_TIMER |-> !timer_out.out_oe)
        else $error("timer drives pin");

    cap_nodrive_a: assert property (@(posedge clk) disable iff (rst) // R22
        m_cap |-> !timer_out.out_oe)
        else $error("capture drives pin");

    force_lvl_a: assert property (@(posedge clk) disable iff (rst) // R8 R10
        m_pwm && !ctrl.out_func_sel[1]
        |-> timer_out.out_oe && timer_out.out_val == ctrl.out_func_sel[0])
        else $error("forced level wrong");

    full_duty_a: assert property (@(posedge clk) disable iff (rst) // R6
        m_pwm && ctrl.out_func_sel == 2'b10 && {1'b0, compare_a_value} >= per
        |-> timer_out.out_val == (ctrl.out_init_level ^ ctrl.out_invert))
        else $error("full duty broken");

    duty_on_a: assert property (@(posedge clk) disable iff (rst) // R25 R8 R9
        m_pwm && ctrl.out_func_sel == 2'b10 && cnt < compare_a_value
        |-> timer_out.out_val == (ctrl.out_init_level ^ ctrl.out_invert))
        else $error("duty phase inactive");

    zero_duty_a: assert property (@(posedge clk) disable iff (rst) // R25 R9
        m_pwm && ctrl.out_func_sel == 2'b10 && compare_a_value == 10'h000
        |-> timer_out.out_val == (!ctrl.out_init_level ^ ctrl.out_invert))
        else $error("zero duty active");

    // counter and flags
    pwm_per_a: assert property (@(posedge clk) disable iff (rst) // R5
        m_pwm && running && period_value == 10'h000 && cnt == `PTM_CNT_MAX
        |=> cnt == 10'h000)
        else $error("long period not closed");

    p_clear_a: assert property (@(posedge clk) disable iff (rst) // R4 R18
        p_hit |=> cnt == 10'h000)
        else $error("period match kept count");

    pwm_flag_a: assert property (@(posedge clk) disable iff (rst) // R7 R10
        m_pwm && running && (eq_a || eq_p)
        |-> match_a_evt == eq_a && match_p_evt == eq_p)
        else $error("pwm match event wrong");

    tc_flag_a: assert property (@(posedge clk) disable iff (rst) // R1
        ctrl.mode == PTM_MODE_TIMER && running && eq_a |-> match_a_evt)
        else $error("timer match a missing");

    cap_p_a: assert property (@(posedge clk) disable iff (rst) // R18
        m_cap && running && eq_p |-> match_p_evt)
        else $error("capture period event missing");

    cap_hold_a: assert property (@(posedge clk) disable iff (rst) // R18
        !ctrl.run |=> cnt == $past(cnt))
        else $error("counter moved while stopped");

    flag_set_a: assert property (@(posedge clk) disable iff (rst) // R7
        match_p_evt |=> match_p_flag)
        else $error("match p flag missing");

    // capture
    edge_clr_a: assert property (@(posedge clk) disable iff (rst) // R19
        edge_clr |=> cnt == 10'h000)
        else $error("edge did not clear counter");

    cap_latch_a: assert property (@(posedge clk) disable iff (rst) // R17
        cap_edge && !to_b && !wr_a |=> compare_a_value == $past(cnt))
        else $error("capture lost");

    cap_b_a: assert property (@(posedge clk) disable iff (rst) // R17
        to_b |=> capture_b_value == $past(cnt))
        else $error("capture into b lost");

    edge_flag_a: assert property (@(posedge clk) disable iff (rst) // R23
        cap_edge |=> latch_edge_flag == $past(rise))
        else $error("edge flag wrong");

    cap_only_a: assert property (@(posedge clk) disable iff (rst) // R20
        capture_clear_sel == 2'b00 |-> !to_b)
        else $error("capture into b");

    no_cap_a: assert property (@(posedge clk) disable iff (rst) // R16
        ctrl.out_func_sel == 2'b11 |-> !cap_edge)
        else $error("capture with 11");
endmodule : ptm_timer

/* File: src/ptm_defines.svh */
// offsets, field positions, reset values and counts for the periodic timer
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH
`define PTM_CNT_W        10
`define PTM_CNT_MAX      10'h3FF
`define PTM_ADDR_W       4
`define PTM_OFF_CTRL     4'h0
`define PTM_OFF_CTRL2    4'h1
`define PTM_OFF_CNT      4'h2
`define PTM_OFF_COMPARE_A_VALUE     4'h3
`define PTM_OFF_CAPTURE_B_VALUE     4'h4
`define PTM_OFF_PERIOD_VALUE     4'h5
`define PTM_OFF_FLAGS    4'h6
`define PTM_CTRL_RST     32'h0000_0000
`define PTM_B_CCLR       0
`define PTM_B_CAPTS      1
`define PTM_B_INV        2
`define PTM_B_OCL        3
`define PTM_B_IOLO       4
`define PTM_B_MODELO     6
`define PTM_B_RUN        8
`define PTM_B_DIV        12
`define PTM_B_TCLR       1
`define PTM_F_MA         0
`define PTM_F_MP         1
`define PTM_F_EDGE       2
`endif

/* File: src/ptm_pkg.sv */
// types shared by the periodic timer
package ptm_pkg;
    typedef enum logic [1:0] {
        PTM_MODE_CMP   = 2'b00,
        PTM_MODE_CAP   = 2'b01,
        PTM_MODE_PWM   = 2'b10,
        PTM_MODE_TIMER = 2'b11
    } ptm_mode_e;
    typedef struct packed {
        logic [3:0]  clk_div;
        logic        run;
        logic [1:0]  mode;
        logic [1:0]  out_func_sel;
        logic        out_init_level;
        logic        out_invert;
        logic        capture_src_sel;
        logic        clear_src_sel;
    } ptm_ctrl_s;
    typedef struct packed {
        logic        out_val;
        logic        out_oe;
    } ptm_pin_s;
endpackage : ptm_pkg

/* File: test/ptm_pin_model.sv */
// pin-side model: capture and trigger sources, pull-down load on the output
module ptm_pin_model
    import ptm_pkg::*;
(
    // clock
    input  wire logic     clk,
    // pins
    output logic          ext_clock_pin,
    output logic          capture_pin,
    input  wire ptm_pin_s timer_out,
    // level seen by the load
    output logic          pin_level
);
    timeunit 1ns;
    timeprecision 100ps;
    // a released pin falls to the load's pull-down
    assign pin_level = timer_out.out_oe ? timer_out.out_val : 1'h0;
    initial begin
        ext_clock_pin = 1'h0;
        capture_pin   = 1'h0;
    end
    // one pulse on the chosen pin, both phases well over two timer clocks
    task automatic pulse(input logic on_ext, input int hi, input int lo);
        @(posedge clk);
        {ext_clock_pin, capture_pin} <= on_ext ? 2'h2 : 2'h1;
        repeat (hi) @(posedge clk);
        {ext_clock_pin, capture_pin} <= 2'h0;
        repeat (lo) @(posedge clk);
    endtask : pulse
endmodule : ptm_pin_model

/* File: test/ptm_timer_test.sv */
// self-checking bench for the periodic timer
`include "ptm_defines.svh"
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", w, e, g); end end
module ptm_timer_test
    import ptm_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_clock_pin;
    logic        capture_pin;
    ptm_pin_s    timer_out;
    logic        match_a_evt;
    logic        match_p_evt;
    logic        pin;
    logic [31:0] q;
    int          hi;
    int          mp;
    int          ma;
    int          errors = 0;
    int          comparisons = 0;
    always #12.5 clk = ~clk;
    ptm_timer dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin), .timer_out(timer_out),
        .match_a_evt(match_a_evt), .match_p_evt(match_p_evt));
    ptm_pin_model pm (.clk(clk), .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
        .timer_out(timer_out), .pin_level(pin));
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        bus(1'h0, a, 32'h0000_0000);
    endtask : rd
    function automatic logic [31:0] cw(logic [1:0] m, logic [1:0] f, logic [3:0] lo, logic r);
        return {23'h0, r, m, f, lo};
    endfunction : cw
    task automatic measure(input int c);
        hi = 0;
        mp = 0;
        ma = 0;
        repeat (c) begin
            @(negedge clk);
            hi += int'(pin === 1'h1);
            mp += int'(match_p_evt === 1'h1);
            ma += int'(match_a_evt === 1'h1);
        end
        @(posedge clk);
    endtask : measure
    task automatic t_reset();
        rd(`PTM_OFF_CNT);
        `CHK("counter", 32'h0000_0000, q)
        wr(4'h7, 32'hFFFF_FFFF);
        rd(4'h7);
        `CHK("unmapped", 32'h0000_0000, q)
        wr(`PTM_OFF_CTRL, cw(2'h3, 2'h0, 4'h0, 1'h0));
        `CHK("oe", 1'h0, timer_out.out_oe)
    endtask : t_reset
    task automatic t_timer();
        wr(`PTM_OFF_PERIOD_VALUE, 32'h0000_000A);
        wr(`PTM_OFF_COMPARE_A_VALUE, 32'h0000_0005);
        wr(`PTM_OFF_CTRL, cw(2'h3, 2'h2, 4'h8, 1'h1));
        measure(40);
        `CHK("timer p", 4, mp)
        `CHK("timer a", 4, ma)
        `CHK("timer pin", 0, hi)
        rd(`PTM_OFF_CNT);
        `CHK("count range", 1'h1, q < 32'h0000_000A)
        wr(`PTM_OFF_CTRL, cw(2'h3, 2'h2, 4'h8, 1'h0));
        rd(`PTM_OFF_FLAGS);
        `CHK("timer flags", 2'h3, q[1:0])
        wr(`PTM_OFF_FLAGS, 32'h0000_0003);
        rd(`PTM_OFF_FLAGS);
        `CHK("flags cleared", 2'h0, q[1:0])
    endtask : t_timer
    task automatic t_pwm();
        int h;
        int f;
        wr(`PTM_OFF_PERIOD_VALUE, 32'h0000_0008);
        wr(`PTM_OFF_COMPARE_A_VALUE, 32'h0000_0003);
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h2, 4'h8, 1'h1));
        measure(16);
        measure(32);
        h = hi;
        `CHK("pwm duty", 1'h1, h == 12 || h == 20)
        `CHK("pwm p", 4, mp)
        `CHK("pwm a", 4, ma)
        `CHK("pwm oe", 1'h1, timer_out.out_oe)
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h2, 4'hC, 1'h1));
        measure(32);
        `CHK("inverted", 32 - h, hi)
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h2, 4'h0, 1'h1));
        measure(32);
        `CHK("polarity", 32 - h, hi)
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h2, 4'h9, 1'h1));
        measure(32);
        `CHK("clear source", h, hi)
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h0, 4'h8, 1'h1));
        measure(32);
        f = hi;
        `CHK("forced level", 1'h1, f == 0 || f == 32)
        `CHK("forced p", 4, mp)
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h1, 4'h8, 1'h1));
        measure(32);
        `CHK("forced other", 32 - f, hi)
        `CHK("forced a", 4, ma)
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h2, 4'h8, 1'h1));
        wr(`PTM_OFF_COMPARE_A_VALUE, 32'h0000_0008);
        measure(32);
        `CHK("full duty", h == 12 ? 32 : 0, hi)
        wr(`PTM_OFF_COMPARE_A_VALUE, 32'h0000_0003);
        wr(`PTM_OFF_PERIOD_VALUE, 32'h0000_0000);
        measure(2048);
        `CHK("period 1024", 2, mp)
        `CHK("duty 1024", h == 12 ? 6 : 2042, hi)
    endtask : t_pwm
    task automatic t_pulse();
        int idle;
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h3, 4'h9, 1'h0));
        wr(`PTM_OFF_COMPARE_A_VALUE, 32'h0000_0014);
        wr(`PTM_OFF_PERIOD_VALUE, 32'h0000_0003);
        measure(4);
        idle = hi;
        wr(`PTM_OFF_FLAGS, 32'h0000_0003);
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h3, 4'h9, 1'h1));
        measure(60);
        hi = idle == 0 ? hi : 60 - hi;
        `CHK("pulse width", 1'h1, hi >= 17 && hi <= 21)
        rd(`PTM_OFF_CTRL);
        `CHK("run cleared", 1'h0, q[8])
        rd(`PTM_OFF_FLAGS);
        `CHK("pulse flag", 1'h1, q[0])
        pm.pulse(1'h1, 6, 6);
        rd(`PTM_OFF_CTRL);
        `CHK("run by pin", 1'h1, q[8])
        measure(40);
        rd(`PTM_OFF_CTRL);
        `CHK("run ended", 1'h0, q[8])
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h3, 4'h9, 1'h1));
        wr(`PTM_OFF_CTRL, cw(2'h2, 2'h3, 4'h9, 1'h0));
        measure(4);
        `CHK("soft end", idle, hi)
    endtask : t_pulse
    task automatic t_capture();
        wr(`PTM_OFF_CTRL, cw(2'h1, 2'h0, 4'h0, 1'h0));
        wr(`PTM_OFF_CTRL2, 32'h0000_0000);
        wr(`PTM_OFF_PERIOD_VALUE, 32'h0000_0010);
        wr(`PTM_OFF_COMPARE_A_VALUE, 32'h0000_0000);
        wr(`PTM_OFF_CTRL, cw(2'h1, 2'h3, 4'hC, 1'h1));
        pm.pulse(1'h0, 8, 8);
        measure(64);
        `CHK("cap p", 4, mp)
        `CHK("cap oe", 1'h0, timer_out.out_oe)
        rd(`PTM_OFF_COMPARE_A_VALUE);
        `CHK("no capture", 32'h0000_0000, q)
        for (int f = 0; f < 3; f++) begin
            wr(`PTM_OFF_CTRL, cw(2'h1, 2'(f), 4'h2, 1'h1));
            wr(`PTM_OFF_FLAGS, 32'h0000_0003);
            pm.pulse(1'h0, 8, 8);
            rd(`PTM_OFF_FLAGS);
            `CHK("other pin", 1'h0, q[0])
            pm.pulse(1'h1, 8, 8);
            rd(`PTM_OFF_FLAGS);
            `CHK("capture flag", 1'h1, q[0])
        end
        wr(`PTM_OFF_PERIOD_VALUE, 32'h0000_0000);
        for (int t = 0; t < 2; t++) begin
            wr(`PTM_OFF_CTRL2, t ? 32'h0000_0006 : 32'h0000_0000);
            for (int f = 0; f < 3; f++) begin
                wr(`PTM_OFF_CAPTURE_B_VALUE, 32'h0000_0000);
                wr(`PTM_OFF_CTRL, cw(2'h1, 2'(f), 4'h0, 1'h1));
                pm.pulse(1'h0, 50, 10);
                rd(`PTM_OFF_CAPTURE_B_VALUE);
                if (t == 0) begin
                    `CHK("capture_b_value unused", 32'h0000_0000, q)
                end else begin
                    `CHK("clear on edge", 1'h1, f == 0 ? q == 0 : q >= 45 && q <= 55)
                    rd(`PTM_OFF_CTRL2);
                    `CHK("edge flag", f == 0 ? 1'h1 : 1'h0, q[0])
                end
            end
        end
    endtask : t_capture
    task automatic conclude();
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_timer();
        t_pwm();
        t_pulse();
        t_capture();
        conclude();
    end
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule : ptm_timer_test
